// file: rtl/cfs_cfg.svh
// Purpose: constants of the cube face select block
// Assumes: included by bare name
// Notes: widths, fixed-point layout and divider length
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH

// ==========================================================
// data widths
`define CFS_COORD_W 16
`define CFS_MAG_W 17
`define CFS_SIZE_W 12
`define CFS_IDX_W 13
`define CFS_FRAC 8
`define CFS_HALF 22'sh000080
`define CFS_U_W 21
`define CFS_NUM_W 37
`define CFS_REM_W 18
`define CFS_CNT_W 6
`define CFS_TAPS 4

// ==========================================================
// corner texel mean
`define CFS_TEX_W 32
`define CFS_CH_W 8
`define CFS_CHANS 4
`define CFS_RECIP3 9'h0AB
`define CFS_RECIP3_SH 9

`endif

// file: rtl/cfs_pkg.sv
// Purpose: types and shared decoding functions of the cube face select block
// Assumes: cfs_cfg.svh holds the numbers
// Notes: face order follows the major axis table
`include "cfs_cfg.svh"
package cfs_pkg;

	// ==========================================================
	// faces and control states
	typedef enum logic [2:0] {
		CFS_POS_X = 3'h0,
		CFS_NEG_X = 3'h1,
		CFS_POS_Y = 3'h2,
		CFS_NEG_Y = 3'h3,
		CFS_POS_Z = 3'h4,
		CFS_NEG_Z = 3'h5
	} cfs_face_t;

	typedef enum logic [1:0] {
		CFS_IDLE = 2'h0,
		CFS_DIV = 2'h1,
		CFS_FIN = 2'h3,
		CFS_DONE = 2'h2
	} cfs_state_t;

	typedef enum logic [1:0] {
		CFS_EDGE_L = 2'h0,
		CFS_EDGE_R = 2'h1,
		CFS_EDGE_T = 2'h2,
		CFS_EDGE_B = 2'h3
	} cfs_edge_t;

	// ==========================================================
	// shared decoding
	typedef logic signed [`CFS_IDX_W-1:0] cfs_idx_t;

	function automatic logic [`CFS_MAG_W-1:0] mag(input logic signed [`CFS_COORD_W-1:0] v);
		logic signed [`CFS_MAG_W-1:0] e;
		e = {v[`CFS_COORD_W-1], v};
		return v[`CFS_COORD_W-1] ? 17'(-e) : 17'(e);
	endfunction

	function automatic cfs_idx_t eclamp(input cfs_idx_t v, input cfs_idx_t sz);
		if (v < 0) return 13'sh0000;
		if (v > sz - 13'sh0001) return 13'(sz - 13'sh0001);
		return v;
	endfunction

	function automatic cfs_idx_t bclamp(input cfs_idx_t v, input cfs_idx_t sz);
		if (v < -13'sh0001) return -13'sh0001;
		if (v > sz) return sz;
		return v;
	endfunction

	// neighbour face and index across edge e; k runs along the edge
	function automatic logic [28:0] nbr(input logic [2:0] f, input cfs_edge_t e,
		input cfs_idx_t k, input cfs_idx_t sz);
		cfs_idx_t m;
		cfs_idx_t r;
		m = 13'(sz - 13'sh0001);
		r = 13'(m - k);
		unique case ({f, e})
			{3'h0, CFS_EDGE_L}: return {3'h4, m, k};
			{3'h0, CFS_EDGE_R}: return {3'h5, 13'h0, k};
			{3'h0, CFS_EDGE_T}: return {3'h2, m, r};
			{3'h0, CFS_EDGE_B}: return {3'h3, m, k};
			{3'h1, CFS_EDGE_L}: return {3'h5, m, k};
			{3'h1, CFS_EDGE_R}: return {3'h4, 13'h0, k};
			{3'h1, CFS_EDGE_T}: return {3'h2, 13'h0, k};
			{3'h1, CFS_EDGE_B}: return {3'h3, 13'h0, r};
			{3'h2, CFS_EDGE_L}: return {3'h1, k, 13'h0};
			{3'h2, CFS_EDGE_R}: return {3'h0, r, 13'h0};
			{3'h2, CFS_EDGE_T}: return {3'h5, r, 13'h0};
			{3'h2, CFS_EDGE_B}: return {3'h4, k, 13'h0};
			{3'h3, CFS_EDGE_L}: return {3'h1, r, m};
			{3'h3, CFS_EDGE_R}: return {3'h0, k, m};
			{3'h3, CFS_EDGE_T}: return {3'h4, k, m};
			{3'h3, CFS_EDGE_B}: return {3'h5, r, m};
			{3'h4, CFS_EDGE_L}: return {3'h1, m, k};
			{3'h4, CFS_EDGE_R}: return {3'h0, 13'h0, k};
			{3'h4, CFS_EDGE_T}: return {3'h2, k, m};
			{3'h4, CFS_EDGE_B}: return {3'h3, k, 13'h0};
			{3'h5, CFS_EDGE_L}: return {3'h0, m, k};
			{3'h5, CFS_EDGE_R}: return {3'h1, 13'h0, k};
			{3'h5, CFS_EDGE_T}: return {3'h2, r, 13'h0};
			{3'h5, CFS_EDGE_B}: return {3'h3, r, m};
			default: return {3'h0, k, k};
		endcase
	endfunction

endpackage

// file: rtl/cfs_corner_mean.sv
// Purpose: synthesises the missing corner texel of a seamless cube fetch
// Assumes: four 8-bit channels per texel
// Notes: mean of three by multiply with a reciprocal, exact for equal inputs
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module cfs_corner_mean
	import cfs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// three available samples
	input wire logic corner_valid,
	input wire logic [`CFS_TEX_W-1:0] tex_a,
	input wire logic [`CFS_TEX_W-1:0] tex_b,
	input wire logic [`CFS_TEX_W-1:0] tex_c,
	// synthesised texel
	output logic mean_valid,
	output logic [`CFS_TEX_W-1:0] mean_texel
);

	logic [`CFS_TEX_W-1:0] mean_next;

	// ==========================================================
	// per channel mean
	for (genvar c = 0; c < `CFS_CHANS; c++) begin : g_chan
		logic [9:0] sum;
		logic [18:0] prod;
		always_comb begin
			sum = 10'(tex_a[c*`CFS_CH_W +: `CFS_CH_W]) + 10'(tex_b[c*`CFS_CH_W +: `CFS_CH_W])
				+ 10'(tex_c[c*`CFS_CH_W +: `CFS_CH_W]);
			prod = 19'(sum) * 19'(`CFS_RECIP3); // [R10]
			mean_next[c*`CFS_CH_W +: `CFS_CH_W] = prod[`CFS_RECIP3_SH +: `CFS_CH_W]; // [R11]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mean_valid <= 1'b0;
			mean_texel <= 32'h0;
		end else if (ce) begin
			mean_valid <= corner_valid;
			if (corner_valid) begin
				mean_texel <= mean_next;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_corner_equal: assert property (ce && corner_valid && tex_a == tex_b && tex_b == tex_c
		|=> mean_texel == $past(tex_a)) // [R11]
		else $error("corner texel differs from equal samples");

	a_corner_span: assert property (ce && corner_valid |=> mean_valid) // [R10]
		else $error("corner texel not produced");

endmodule

// file: rtl/cfs_cube_select.sv
// Purpose: cube map face selection, face coordinates and seamless taps
// Assumes: coordinates from the fragment pipeline on ref_clk; face_size >= 1
// Notes: 37-cycle divider; one vector in flight; taps ignore wrap modes
`timescale 1ns/1ps
`include "cfs_cfg.svh"
// Functional notes
// [R1] the three coordinates form a direction from the cube centre
// [R2] the face is the largest-magnitude component with its sign
// [R3] equal magnitudes resolve by a fixed rule depending only on the vector
// [R4] each face takes its raw s, t and major value from a fixed table
// [R5] face coordinate is half of raw over abs major plus one
// [R6] programmed wrap modes are ignored; seamless handling is fixed
// [R7] nearest sampling within a level always uses edge clamping
// [R8] linear sampling within a level uses border clamping
// [R9] a tap in the border of one axis comes from the neighbour face
// [R10] a tap in both borders is synthesised as mean of three samples
// [R11] three equal samples yield that same corner value
// [R12] edge clamping keeps indices within zero to size minus one
// [R13] border clamping keeps indices within minus one to size
// [R14] ties prefer X over Y and Y over Z
module cfs_cube_select
	import cfs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// direction vector in
	input wire logic in_valid,
	output logic in_ready,
	input wire logic signed [`CFS_COORD_W-1:0] in_s,
	input wire logic signed [`CFS_COORD_W-1:0] in_t,
	input wire logic signed [`CFS_COORD_W-1:0] in_r,
	input wire logic in_linear,
	input wire logic [`CFS_SIZE_W-1:0] in_face_size,
	// taps out
	output logic out_valid,
	input wire logic out_ready,
	output logic [2:0] out_face,
	output logic out_linear,
	output logic [`CFS_U_W-1:0] face_s,
	output logic [`CFS_U_W-1:0] face_t,
	output logic [`CFS_FRAC-1:0] frac_s,
	output logic [`CFS_FRAC-1:0] frac_t,
	output logic [`CFS_TAPS-1:0][2:0] tap_face,
	output logic [`CFS_TAPS-1:0][`CFS_IDX_W-1:0] tap_i,
	output logic [`CFS_TAPS-1:0][`CFS_IDX_W-1:0] tap_j,
	output logic [`CFS_TAPS-1:0] tap_nbr,
	output logic [`CFS_TAPS-1:0] tap_corner,
	// corner synthesis
	input wire logic corner_valid,
	input wire logic [`CFS_TEX_W-1:0] corner_a,
	input wire logic [`CFS_TEX_W-1:0] corner_b,
	input wire logic [`CFS_TEX_W-1:0] corner_c,
	output logic corner_out_valid,
	output logic [`CFS_TEX_W-1:0] corner_texel
);

	// ==========================================================
	// face selection and raw coordinates
	cfs_state_t state_reg;
	logic [`CFS_MAG_W-1:0] ax, ay, az, ama;
	logic [2:0] face_next;
	logic signed [`CFS_MAG_W-1:0] px, py, pz, sc, tc;
	logic [`CFS_MAG_W-1:0] ssum, tsum;
	logic signed [`CFS_COORD_W-1:0] vx_reg, vy_reg, vz_reg;

	always_comb begin
		ax = mag(in_s); // [R1]
		ay = mag(in_t);
		az = mag(in_r);
		px = {in_s[`CFS_COORD_W-1], in_s};
		py = {in_t[`CFS_COORD_W-1], in_t};
		pz = {in_r[`CFS_COORD_W-1], in_r};
		if (ax >= ay && ax >= az) begin // [R2] [R3] [R14]
			face_next = in_s[`CFS_COORD_W-1] ? CFS_NEG_X : CFS_POS_X;
			ama = ax;
		end else if (ay >= az) begin
			face_next = in_t[`CFS_COORD_W-1] ? CFS_NEG_Y : CFS_POS_Y;
			ama = ay;
		end else begin
			face_next = in_r[`CFS_COORD_W-1] ? CFS_NEG_Z : CFS_POS_Z;
			ama = az;
		end
		sc = (face_next == CFS_POS_X) ? -pz : (face_next == CFS_NEG_X) ? pz : // [R4]
			(face_next == CFS_NEG_Z) ? -px : px;
		tc = (face_next == CFS_POS_Y) ? pz : (face_next == CFS_NEG_Y) ? -pz : -py;
		ssum = 17'(sc + $signed(ama)); // [R5]
		tsum = 17'(tc + $signed(ama));
	end

	// ==========================================================
	// divider: size * (raw + |major|) / (2 |major|) in 1/256 texel units
	logic [`CFS_NUM_W-1:0] num_s_reg, num_t_reg, quo_s_reg, quo_t_reg;
	logic [`CFS_REM_W-1:0] rem_s_reg, rem_t_reg, den_reg;
	logic [`CFS_CNT_W-1:0] cnt_reg;
	logic [`CFS_REM_W:0] trial_s, trial_t;
	logic [`CFS_SIZE_W-1:0] size_reg;
	logic linear_reg, accept;
	logic [2:0] face_reg;

	assign accept = in_valid && in_ready;
	assign trial_s = {rem_s_reg, num_s_reg[`CFS_NUM_W-1]};
	assign trial_t = {rem_t_reg, num_t_reg[`CFS_NUM_W-1]};

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= CFS_IDLE;
			in_ready <= 1'b0;
			cnt_reg <= 6'h0;
		end else if (ce) begin
			unique case (state_reg)
				CFS_IDLE: begin
					in_ready <= !accept;
					if (accept) begin
						state_reg <= CFS_DIV;
						cnt_reg <= 6'(`CFS_NUM_W - 1);
					end
				end
				CFS_DIV: begin
					cnt_reg <= cnt_reg - 6'h01;
					if (cnt_reg == 6'h0) state_reg <= CFS_FIN;
				end
				CFS_FIN: state_reg <= CFS_DONE;
				CFS_DONE: begin
					if (out_ready) begin
						state_reg <= CFS_IDLE;
						in_ready <= 1'b1;
					end
				end
			endcase
		end
	end

	// datapath needs no reset: nothing reads it before a vector is taken
	always_ff @(posedge ref_clk) begin
		if (ce) begin
			if (state_reg == CFS_IDLE && accept) begin
				num_s_reg <= {29'(ssum * in_face_size), 8'h0};
				num_t_reg <= {29'(tsum * in_face_size), 8'h0};
				den_reg <= (ama == 17'h0) ? 18'h1 : {ama, 1'b0};
				rem_s_reg <= 18'h0;
				rem_t_reg <= 18'h0;
				size_reg <= in_face_size;
				linear_reg <= in_linear;
				face_reg <= face_next;
				vx_reg <= in_s;
				vy_reg <= in_t;
				vz_reg <= in_r;
			end else if (state_reg == CFS_DIV) begin
				num_s_reg <= num_s_reg << 1;
				num_t_reg <= num_t_reg << 1;
				rem_s_reg <= (trial_s >= {1'b0, den_reg}) ? 18'(trial_s - den_reg) : 18'(trial_s);
				rem_t_reg <= (trial_t >= {1'b0, den_reg}) ? 18'(trial_t - den_reg) : 18'(trial_t);
				quo_s_reg <= {quo_s_reg[`CFS_NUM_W-2:0], trial_s >= {1'b0, den_reg}};
				quo_t_reg <= {quo_t_reg[`CFS_NUM_W-2:0], trial_t >= {1'b0, den_reg}};
			end
		end
	end

	// ==========================================================
	// texel indices and seamless taps
	cfs_idx_t sz, ni, nj, i0, i1, j0, j1;
	logic signed [`CFS_U_W:0] us, ut;
	logic [2:0] tf_n [`CFS_TAPS];
	cfs_idx_t ti_n [`CFS_TAPS], tj_n [`CFS_TAPS];
	logic nbr_n [`CFS_TAPS], cor_n [`CFS_TAPS];

	always_comb begin
		sz = $signed({1'b0, size_reg});
		ni = eclamp($signed({1'b0, quo_s_reg[`CFS_U_W-2:`CFS_FRAC]}), sz); // [R6] [R7] [R12]
		nj = eclamp($signed({1'b0, quo_t_reg[`CFS_U_W-2:`CFS_FRAC]}), sz);
		us = $signed({1'b0, quo_s_reg[`CFS_U_W-1:0]}) - `CFS_HALF;
		ut = $signed({1'b0, quo_t_reg[`CFS_U_W-1:0]}) - `CFS_HALF;
		i0 = bclamp(13'(us >>> `CFS_FRAC), sz); // [R8] [R13]
		j0 = bclamp(13'(ut >>> `CFS_FRAC), sz);
		i1 = bclamp(13'(i0 + 13'sh0001), sz);
		j1 = bclamp(13'(j0 + 13'sh0001), sz);
	end

	for (genvar g = 0; g < `CFS_TAPS; g++) begin : g_tap
		cfs_idx_t ci, cj;
		logic bs, bt;
		always_comb begin
			ci = (g % 2 != 0) ? i1 : i0;
			cj = (g / 2 != 0) ? j1 : j0;
			bs = (ci == -13'sh0001) || (ci == sz);
			bt = (cj == -13'sh0001) || (cj == sz);
			tf_n[g] = face_reg;
			ti_n[g] = ci;
			tj_n[g] = cj;
			nbr_n[g] = 1'b0;
			cor_n[g] = 1'b0;
			if (!linear_reg) begin
				ti_n[g] = ni;
				tj_n[g] = nj;
			end else if (bs && bt) begin
				cor_n[g] = 1'b1; // [R10]
				ti_n[g] = 13'sh0000;
				tj_n[g] = 13'sh0000;
			end else if (bs) begin
				nbr_n[g] = 1'b1; // [R9]
				{tf_n[g], ti_n[g], tj_n[g]} = nbr(face_reg,
					(ci < 0) ? CFS_EDGE_L : CFS_EDGE_R, cj, sz);
			end else if (bt) begin
				nbr_n[g] = 1'b1; // [R9]
				{tf_n[g], ti_n[g], tj_n[g]} = nbr(face_reg,
					(cj < 0) ? CFS_EDGE_T : CFS_EDGE_B, ci, sz);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_face <= 3'h0;
			out_linear <= 1'b0;
			face_s <= 21'h0;
			face_t <= 21'h0;
			frac_s <= 8'h0;
			frac_t <= 8'h0;
			tap_face <= '0;
			tap_i <= '0;
			tap_j <= '0;
			tap_nbr <= 4'h0;
			tap_corner <= 4'h0;
		end else if (ce) begin
			if (state_reg == CFS_FIN) begin
				out_valid <= 1'b1;
				out_face <= face_reg;
				out_linear <= linear_reg;
				face_s <= quo_s_reg[`CFS_U_W-1:0];
				face_t <= quo_t_reg[`CFS_U_W-1:0];
				frac_s <= linear_reg ? us[`CFS_FRAC-1:0] : 8'h0;
				frac_t <= linear_reg ? ut[`CFS_FRAC-1:0] : 8'h0;
				for (int k = 0; k < `CFS_TAPS; k++) begin
					tap_face[k] <= tf_n[k];
					tap_i[k] <= ti_n[k];
					tap_j[k] <= tj_n[k];
					tap_nbr[k] <= nbr_n[k];
					tap_corner[k] <= cor_n[k];
				end
			end else if (state_reg == CFS_DONE && out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end

	cfs_corner_mean u_corner (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.corner_valid(corner_valid),
		.tex_a(corner_a),
		.tex_b(corner_b),
		.tex_c(corner_c),
		.mean_valid(corner_out_valid),
		.mean_texel(corner_texel)
	);

	// ==========================================================
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_major_axis: assert property (out_valid |-> (out_face[2:1] == 2'h0 ? // [R2]
		mag(vx_reg) >= mag(vy_reg) && mag(vx_reg) >= mag(vz_reg) :
		out_face[2:1] == 2'h1 ? mag(vy_reg) >= mag(vz_reg) && mag(vy_reg) > mag(vx_reg) :
		mag(vz_reg) > mag(vx_reg) && mag(vz_reg) > mag(vy_reg)))
		else $error("face is not the major axis");
	a_face_sign: assert property (out_valid |-> out_face[0] == (out_face[2:1] == 2'h0 ? // [R2]
		vx_reg[15] : out_face[2:1] == 2'h1 ? vy_reg[15] : vz_reg[15]))
		else $error("face sign mismatch");
	a_tie_xy: assert property (out_valid && mag(vx_reg) == mag(vy_reg) // [R14]
		&& mag(vx_reg) >= mag(vz_reg) |-> out_face[2:1] == 2'h0)
		else $error("tie did not prefer x");
	a_coord_span: assert property (out_valid |-> face_s <= {1'b0, size_reg, 8'h0}) // [R5]
		else $error("face coordinate beyond face");
	a_coord_half: assert property (out_valid && out_face == CFS_POS_Z && vx_reg == 16'h0 // [R4]
		|-> face_s == {2'h0, size_reg, 7'h0})
		else $error("centre vector not at face centre");
	a_nearest_clamp: assert property (out_valid && !out_linear |-> // [R7]
		tap_i[0] <= 13'(sz - 13'sh0001) && !tap_i[0][12] && tap_corner == 4'h0)
		else $error("nearest index outside edge clamp");
	a_linear_range: assert property (out_valid && out_linear && !tap_corner[3] |-> // [R13]
		$signed(tap_i[3]) >= 0 && $signed(tap_i[3]) <= 13'(sz - 13'sh0001))
		else $error("linear tap outside face after remap");
	a_neighbour_face: assert property (out_valid && tap_nbr[0] |-> tap_face[0] != out_face) // [R9]
		else $error("border tap not taken from neighbour");
	sequence s_fin; state_reg == CFS_FIN && ce; endsequence
	sequence s_show; out_valid && !in_ready; endsequence
	a_result_hold: assert property (s_fin |=> s_show) // [R5]
		else $error("result not presented after divide");

endmodule

// file: verification/cfs_frag_source.sv
// Purpose: fragment pipeline model that feeds direction vectors
// Assumes: requests change at the falling edge and are taken on a ce edge with in_ready
// Notes: released lines show the inverted last value, never a stale copy
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module cfs_frag_source
	import cfs_pkg::*;
(
	// clock
	input wire logic ref_clk,
	input wire logic ce,
	// vector handshake
	input wire logic in_ready,
	output logic in_valid,
	output logic signed [`CFS_COORD_W-1:0] in_s,
	output logic signed [`CFS_COORD_W-1:0] in_t,
	output logic signed [`CFS_COORD_W-1:0] in_r,
	output logic in_linear,
	output logic [`CFS_SIZE_W-1:0] in_face_size
);
	initial begin
		in_valid = 1'h0;
		in_s = 16'h0000;
		in_t = 16'h0000;
		in_r = 16'h0000;
		in_linear = 1'h0;
		in_face_size = 12'h001;
	end

	// ==========================================================
	// one vector, held until taken or for at most 400 rising edges
	task automatic send(input int s, input int t, input int r, input bit lin,
		input int size, input int gap, output bit ok);
		int n;
		ok = 1'b0;
		repeat (gap + 1) @(negedge ref_clk);
		in_s = s[`CFS_COORD_W-1:0];
		in_t = t[`CFS_COORD_W-1:0];
		in_r = r[`CFS_COORD_W-1:0];
		in_linear = lin;
		in_face_size = size[`CFS_SIZE_W-1:0];
		in_valid = 1'h1;
		for (n = 0; n < 400 && !ok; n++) begin
			@(posedge ref_clk);
			ok = ce && in_ready === 1'h1;
		end
		@(negedge ref_clk);
		in_valid = 1'h0;
		in_s = ~in_s;
		in_t = ~in_t;
		in_r = ~in_r;
		in_linear = ~in_linear;
		in_face_size = ~in_face_size;
	endtask
endmodule

// file: verification/cfs_cube_select_bench.sv
// Purpose: self-checking bench of the cube face select block
// Assumes: the fragment source model drives the vector side
// Notes: drivers note expected results in queues; watchers compare them
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module cfs_cube_select_bench import cfs_pkg::*;;
	typedef struct {
		logic [2:0] face;
		logic [`CFS_U_W-1:0] fs;
		logic [`CFS_U_W-1:0] ft;
		logic lin;
		bit exact;
		int size;
	} cfs_note_t;

	logic ref_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic ce = 1'h1;
	logic out_ready = 1'h0;
	logic corner_valid = 1'h0;
	logic [`CFS_TEX_W-1:0] corner_a = 32'h0, corner_b = 32'h0, corner_c = 32'h0;
	logic in_valid, in_ready, in_linear, out_valid, out_linear, corner_out_valid;
	logic signed [`CFS_COORD_W-1:0] in_s, in_t, in_r;
	logic [`CFS_SIZE_W-1:0] in_face_size;
	logic [2:0] out_face;
	logic [`CFS_U_W-1:0] face_s, face_t;
	logic [`CFS_FRAC-1:0] frac_s, frac_t;
	logic [`CFS_TAPS-1:0][2:0] tap_face;
	logic [`CFS_TAPS-1:0][`CFS_IDX_W-1:0] tap_i, tap_j;
	logic [`CFS_TAPS-1:0] tap_nbr, tap_corner;
	logic [`CFS_TEX_W-1:0] corner_texel;
	int n_mismatch = 0;
	int samples_checked = 0;
	cfs_note_t note_q[$];
	logic [`CFS_TEX_W:0] mean_q[$];
	int face_vec[6][3] = '{'{64, 10, -20}, '{-64, 10, -20}, '{10, 64, -20},
		'{10, -64, -20}, '{0, -20, 64}, '{10, -20, -64}};
	int edge_vec[10][5] = '{'{64, 64, 5, 0, 16}, '{-64, 64, -64, 0, 16}, '{3, -64, 64, 0, 16},
		'{0, 0, 0, 0, 16}, '{64, -64, -64, 0, 16}, '{64, -62, 0, 1, 16}, '{64, 0, 62, 1, 16},
		'{64, -62, -62, 1, 16}, '{64, -62, -62, 1, 1}, '{64, -62, -62, 0, 1}};

	always #5 ref_clk = ~ref_clk;

	// ==========================================================
	// clock enable and downstream stalls
	always @(negedge ref_clk) begin
		ce <= sys_rst || ($urandom % 8 != 0);
		out_ready <= $urandom % 4 != 0;
	end

	cfs_cube_select cfs_cube_select_i (.ref_clk, .sys_rst, .ce, .in_valid, .in_ready,
		.in_s, .in_t, .in_r, .in_linear, .in_face_size, .out_valid, .out_ready, .out_face,
		.out_linear, .face_s, .face_t, .frac_s, .frac_t, .tap_face, .tap_i, .tap_j,
		.tap_nbr, .tap_corner, .corner_valid, .corner_a, .corner_b, .corner_c,
		.corner_out_valid, .corner_texel);

	cfs_frag_source cfs_frag_source_i (.ref_clk, .ce, .in_ready, .in_valid, .in_s,
		.in_t, .in_r, .in_linear, .in_face_size);

	// ==========================================================
	// comparison and verdict
	task automatic report(input bit bad, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (bad) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		report(got !== exp, got, exp);
	endtask

	task automatic check_near(input logic [31:0] got, input logic [31:0] exp);
		report(got !== exp && got !== exp + 32'h1 && got !== exp - 32'h1, got, exp);
	endtask

	// floor of the true mean, or one above it unless all three samples agree
	task automatic check_mean(input logic [31:0] got, input logic [32:0] exp);
		bit bad;
		int ch, d;
		bad = 1'b0;
		for (ch = 0; ch < 4; ch++) begin
			d = int'(got[8*ch+:8]) - int'(exp[8*ch+:8]);
			bad |= d < 0 || d > (exp[32] ? 0 : 1);
		end
		report(bad || $isunknown(got), got, exp[31:0]);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// expected values
	function automatic int clampi(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction

	function automatic logic [`CFS_U_W-1:0] coord(int c, int m, int size);
		longint v;
		v = m == 0 ? 0 : (longint'(c + m) * size * 128) / m;
		return v[`CFS_U_W-1:0];
	endfunction

	function automatic cfs_note_t expect_of(int rx, int ry, int rz, bit lin, int size, bit ex);
		cfs_note_t e;
		int ax, ay, az, sc, tc, m;
		ax = rx < 0 ? -rx : rx;
		ay = ry < 0 ? -ry : ry;
		az = rz < 0 ? -rz : rz;
		if (ax >= ay && ax >= az) begin
			e.face = rx < 0 ? 3'h1 : 3'h0;
			sc = rx < 0 ? rz : -rz;
			tc = -ry;
			m = ax;
		end else if (ay >= az) begin
			e.face = ry < 0 ? 3'h3 : 3'h2;
			sc = rx;
			tc = ry < 0 ? -rz : rz;
			m = ay;
		end else begin
			e.face = rz < 0 ? 3'h5 : 3'h4;
			sc = rz < 0 ? -rx : rx;
			tc = -ry;
			m = az;
		end
		e.fs = coord(sc, m, size);
		e.ft = coord(tc, m, size);
		e.lin = lin;
		e.size = size;
		e.exact = ex;
		return e;
	endfunction

	// bit 32 marks three equal samples
	function automatic logic [32:0] mean3(logic [31:0] a, logic [31:0] b, logic [31:0] c);
		logic [32:0] r;
		int ch, sum;
		r[32] = a == b && b == c;
		for (ch = 0; ch < 4; ch++) begin
			sum = a[8*ch+:8] + b[8*ch+:8] + c[8*ch+:8];
			r[8*ch+:8] = 8'(sum / 3);
		end
		return r;
	endfunction

	// ==========================================================
	// result watchers
	task automatic check_taps(cfs_note_t e);
		int i0, j0, i, j, k, vs, vt;
		bit bi, bj;
		vs = int'(e.fs) - 128;
		vt = int'(e.ft) - 128;
		i0 = e.lin ? clampi(vs >>> 8, -1, e.size) : clampi(e.fs >> 8, 0, e.size - 1);
		j0 = e.lin ? clampi(vt >>> 8, -1, e.size) : clampi(e.ft >> 8, 0, e.size - 1);
		check_val(frac_s, e.lin ? vs & 255 : 0);
		check_val(frac_t, e.lin ? vt & 255 : 0);
		for (k = 0; k < 4; k++) begin
			i = i0 + (e.lin ? k % 2 : 0);
			j = j0 + (e.lin ? k / 2 : 0);
			bi = i < 0 || i >= e.size;
			bj = j < 0 || j >= e.size;
			if (!bi && !bj) begin
				check_val(tap_i[k], i[`CFS_IDX_W-1:0]);
				check_val(tap_j[k], j[`CFS_IDX_W-1:0]);
				check_val(tap_face[k], e.face);
				check_val({tap_nbr[k], tap_corner[k]}, 0);
			end else if (bi != bj) begin
				check_val(tap_nbr[k] && tap_face[k] != e.face, 1);
			end else begin
				check_val(tap_corner[k], 1);
			end
		end
	endtask

	task automatic check_result(cfs_note_t e);
		check_val(out_face, e.face);
		check_val(out_linear, e.lin);
		check_near(face_s, e.fs);
		check_near(face_t, e.ft);
		if (e.exact) begin
			check_taps(e);
		end
	endtask

	always @(posedge ref_clk) begin
		if (!sys_rst && ce && out_valid === 1'h1 && out_ready) begin
			if (note_q.size() == 0) begin
				report(1'h1, out_face, 0);
			end else begin
				check_result(note_q.pop_front());
			end
		end
		if (!sys_rst && ce && corner_out_valid === 1'h1) begin
			if (mean_q.size() == 0) begin
				report(1'h1, corner_texel, 0);
			end else begin
				check_mean(corner_texel, mean_q.pop_front());
			end
		end
	end

	// ==========================================================
	// drivers
	task automatic vec(int s, int t, int r, bit lin, int size, bit exact);
		bit ok;
		note_q.push_back(expect_of(s, t, r, lin, size, exact));
		cfs_frag_source_i.send(s, t, r, lin, size, $urandom % 3, ok);
		if (!ok) begin
			report(1'h1, 0, 1);
			wrap_up();
		end
	endtask

	task automatic corner(logic [31:0] a, logic [31:0] b, logic [31:0] c);
		int n;
		@(negedge ref_clk);
		corner_valid = 1'h1;
		corner_a = a;
		corner_b = b;
		corner_c = c;
		for (n = 0; n < 100; n++) begin
			@(posedge ref_clk);
			if (ce) break;
		end
		if (n == 100) begin
			report(1'h1, n, 0);
			wrap_up();
		end
		mean_q.push_back(mean3(a, b, c));
	endtask

	initial begin
		int k, s;
		void'($urandom(48831));
		repeat (4) @(negedge ref_clk);
		check_val({in_ready, out_valid, corner_out_valid}, 0);
		sys_rst = 1'h0;
		for (k = 0; k < 12; k++) begin
			vec(face_vec[k/2][0], face_vec[k/2][1], face_vec[k/2][2], k % 2, 16, 1);
		end
		for (k = 0; k < 10; k++) begin
			vec(edge_vec[k][0], edge_vec[k][1], edge_vec[k][2], edge_vec[k][3],
				edge_vec[k][4], 1);
		end
		for (k = 0; k < 40; k++) begin
			vec($urandom_range(65535) - 32768, $urandom_range(65535) - 32768,
				$urandom_range(65535) - 32768, $urandom % 2, $urandom_range(4095, 1), 0);
		end
		for (k = 0; k < 24; k++) begin
			s = $urandom;
			if (k % 3 == 0) begin
				corner(s, s, s);
			end else begin
				corner(s, $urandom, $urandom);
			end
		end
		@(negedge ref_clk);
		corner_valid = 1'h0;
		corner_a = ~corner_a;
		corner_b = ~corner_b;
		corner_c = ~corner_c;
		for (k = 0; k < 2000 && note_q.size() + mean_q.size() > 0; k++) begin
			@(posedge ref_clk);
		end
		if (k == 2000) begin
			report(1'h1, note_q.size(), 0);
		end
		wrap_up();
	end
endmodule
